// ### inc/adc_hs_pkg.sv
// Types shared by the handshake byte output port
package adc_hs_pkg;

	typedef struct packed {
		logic polarity_bit;
		logic overrange;
		logic [11:0] result_bits;
	} result_s;

	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_HI_STROBE,
		SEQ_HI_HOLD,
		SEQ_LO_STROBE,
		SEQ_LO_HOLD,
		SEQ_END_MARK
	} seq_e;

	typedef struct packed {
		seq_e state;
		logic [3:0] strobe_cnt;
		logic saw_low;
		logic mode_d;
		logic push_pend;
		logic status;
		logic conv_start;
		result_s latest;
		result_s cur;
		logic [13:0] data_o;
		logic [13:0] data_oe;
		logic ce_load_n_o;
		logic ce_load_oe;
		logic hb_n_o;
		logic hb_oe;
		logic lb_n_o;
		logic lb_oe;
	} ctrl_s;

endpackage

// ### inc/adc_hs_regs.svh
// Field positions and timing constants of the handshake byte output port
`ifndef ADC_HS_REGS_SVH
`define ADC_HS_REGS_SVH

`define HI_BYTE_MSB 13
`define HI_BYTE_LSB 8
`define LO_BYTE_MSB 7
`define LO_BYTE_LSB 0

`define RESULT_WIDTH 14
`define RESULT_FIFO_DEPTH 4

`define CLK_PERIOD_NS 10
`define LOAD_STROBE_NS 30
`define LOAD_STROBE_CYC ((`LOAD_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/adc_handshake_byte_output.sv
// Handshake and direct byte output sequencer of the converter's digital port
`timescale 1ns/10ps
`include "adc_hs_regs.svh"

module adc_handshake_byte_output (
	// Clock, reset and enable
	input logic SYS_CLK,
	input logic RST_N,
	input logic CLK_EN,
	// Control pins
	input logic MODE,
	input logic SEND,
	input logic RUN_HOLD,
	output logic STATUS,
	// Chip-enable/load pin, active low
	input logic CE_LOAD_N_I,
	output logic CE_LOAD_N_O,
	output logic CE_LOAD_OE,
	// Byte flag pins, active low
	input logic HIGH_BYTE_FLAG_N_I,
	output logic HIGH_BYTE_FLAG_N_O,
	output logic HIGH_BYTE_FLAG_OE,
	input logic LOW_BYTE_FLAG_N_I,
	output logic LOW_BYTE_FLAG_N_O,
	output logic LOW_BYTE_FLAG_OE,
	// Three-state data pins
	output logic [13:0] DATA_O,
	output logic [13:0] DATA_OE,
	// Converter core, same clock
	input logic CONV_DONE,
	input adc_hs_pkg::result_s CONV_RESULT,
	output logic CONV_START
);
	import adc_hs_pkg::*;

	ctrl_s r;
	ctrl_s n;
	logic [5:0] pins_s;
	logic mode_s;
	logic send_s;
	logic run_s;
	logic ce_n_s;
	logic hb_n_s;
	logic lb_n_s;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	result_s fifo_out;
	logic hs_active;
	logic strobe_last;

	// Active-low enables and send rest high; a zero reset would fake a bus enable
	pin_sync #(
		.W(6),
		.RST_VAL(6'h17)
	) u_pin_sync (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.ce(CLK_EN),
		.d({MODE, SEND, RUN_HOLD, CE_LOAD_N_I, HIGH_BYTE_FLAG_N_I, LOW_BYTE_FLAG_N_I}),
		.q(pins_s)
	);

	assign {mode_s, send_s, run_s, ce_n_s, hb_n_s, lb_n_s} = pins_s;

	// Results wait here so a slow receiver stalls conversions instead of losing data
	result_fifo #(
		.WIDTH(`RESULT_WIDTH),
		.DEPTH(`RESULT_FIFO_DEPTH)
	) u_result_fifo (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.ce(CLK_EN),
		.in_valid(r.push_pend),
		.in_ready(fifo_in_ready),
		.in_data(r.latest),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	assign fifo_pop = (r.state == SEQ_IDLE) && mode_s && send_s && fifo_out_valid;
	assign strobe_last = r.strobe_cnt == 4'h0;

	always_comb begin
		n = r;
		n.conv_start = 1'b0;
		n.mode_d = mode_s;

		// Clear first so a new request in the same cycle wins
		if (r.push_pend && fifo_in_ready) begin
			n.push_pend = 1'b0;
		end
		if (CONV_DONE) begin
			n.latest = CONV_RESULT;
			n.status = 1'b0;
			if (mode_s) begin
				n.push_pend = 1'b1;
			end
		end
		if (mode_s && !r.mode_d) begin
			n.push_pend = 1'b1;
		end
		// Next conversion only once the last result has a place to go
		if (run_s && !r.status && !r.push_pend && !CONV_DONE) begin
			n.status = 1'b1;
			n.conv_start = 1'b1;
		end

		unique case (r.state)
			SEQ_IDLE: begin
				if (fifo_pop) begin
					n.cur = fifo_out;
					n.state = SEQ_HI_STROBE;
					n.strobe_cnt = 4'(`LOAD_STROBE_CYC - 1);
				end
			end
			SEQ_HI_STROBE: begin
				if (strobe_last) begin
					n.state = SEQ_HI_HOLD;
					n.saw_low = 1'b0;
				end else begin
					n.strobe_cnt = r.strobe_cnt - 4'h1;
				end
			end
			SEQ_HI_HOLD: begin
				if (!send_s) begin
					n.saw_low = 1'b1;
				end else if (r.saw_low) begin
					n.state = SEQ_LO_STROBE;
					n.strobe_cnt = 4'(`LOAD_STROBE_CYC - 1);
				end
			end
			SEQ_LO_STROBE: begin
				if (strobe_last) begin
					n.state = SEQ_LO_HOLD;
					n.saw_low = 1'b0;
				end else begin
					n.strobe_cnt = r.strobe_cnt - 4'h1;
				end
			end
			SEQ_LO_HOLD: begin
				if (!send_s) begin
					n.saw_low = 1'b1;
				end else if (r.saw_low) begin
					n.state = SEQ_END_MARK;
				end
			end
			SEQ_END_MARK: begin
				n.state = SEQ_IDLE;
			end
			default: begin
				n.state = SEQ_IDLE;
			end
		endcase

		// Pin drivers follow the next state so every pin leaves a flip-flop
		hs_active = mode_s || (n.state != SEQ_IDLE);
		n.ce_load_oe = hs_active;
		n.hb_oe = hs_active;
		n.lb_oe = hs_active;
		n.ce_load_n_o = !((n.state == SEQ_HI_STROBE) || (n.state == SEQ_LO_STROBE));
		n.hb_n_o = !((n.state == SEQ_HI_STROBE) || (n.state == SEQ_HI_HOLD));
		n.lb_n_o = !((n.state == SEQ_LO_STROBE) || (n.state == SEQ_LO_HOLD));
		n.data_oe = '0;
		if (hs_active) begin
			n.data_o = n.cur;
			if (!n.hb_n_o) begin
				n.data_oe[`HI_BYTE_MSB:`HI_BYTE_LSB] = '1;
			end
			if (!n.lb_n_o) begin
				n.data_oe[`LO_BYTE_MSB:`LO_BYTE_LSB] = '1;
			end
		end else begin
			// Send is assumed tied high here, so no pacing is looked at
			n.data_o = n.latest;
			if (!ce_n_s && !hb_n_s) begin
				n.data_oe[`HI_BYTE_MSB:`HI_BYTE_LSB] = '1;
			end
			if (!ce_n_s && !lb_n_s) begin
				n.data_oe[`LO_BYTE_MSB:`LO_BYTE_LSB] = '1;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			r <= '{state: SEQ_IDLE, ce_load_n_o: 1'b1, hb_n_o: 1'b1, lb_n_o: 1'b1, default: '0};
		end else if (CLK_EN) begin
			r <= n;
		end
	end

	assign STATUS = r.status;
	assign CE_LOAD_N_O = r.ce_load_n_o;
	assign CE_LOAD_OE = r.ce_load_oe;
	assign HIGH_BYTE_FLAG_N_O = r.hb_n_o;
	assign HIGH_BYTE_FLAG_OE = r.hb_oe;
	assign LOW_BYTE_FLAG_N_O = r.lb_n_o;
	assign LOW_BYTE_FLAG_OE = r.lb_oe;
	assign DATA_O = r.data_o;
	assign DATA_OE = r.data_oe;
	assign CONV_START = r.conv_start;

	default clocking cb @(posedge SYS_CLK iff CLK_EN);
	endclocking
	default disable iff (!RST_N);

	sequence s_hi_taken;
		(r.state == SEQ_HI_HOLD) && r.saw_low && send_s;
	endsequence

	sequence s_lo_taken;
		(r.state == SEQ_LO_HOLD) && r.saw_low && send_s;
	endsequence

	sequence s_strobe_pulse;
		!CE_LOAD_N_O [*3] ##1 CE_LOAD_N_O;
	endsequence

	a_strobe_width: assert property (
		$fell(CE_LOAD_N_O) |-> CE_LOAD_OE ##0 s_strobe_pulse
	) else $error("load strobe width wrong");

	a_send_strobes: assert property (
		(r.state == SEQ_IDLE) && mode_s && send_s && fifo_out_valid
		|=> !CE_LOAD_N_O && !HIGH_BYTE_FLAG_N_O && HIGH_BYTE_FLAG_OE
	) else $error("pending byte not strobed");

	a_hold_byte: assert property (
		(r.state == SEQ_HI_HOLD) && !send_s
		|=> (r.state == SEQ_HI_HOLD) && (DATA_OE[`HI_BYTE_MSB:`HI_BYTE_LSB] == 6'h3F)
	) else $error("high byte dropped while send low");

	a_advance_low: assert property (
		s_hi_taken |=> !LOW_BYTE_FLAG_N_O && HIGH_BYTE_FLAG_N_O ##3 (r.state == SEQ_LO_HOLD)
	) else $error("no advance to low byte");

	a_high_first: assert property (
		$rose(r.state == SEQ_LO_STROBE) |-> $past(r.state) == SEQ_HI_HOLD
	) else $error("low byte before high byte");

	a_end_mark: assert property (
		s_lo_taken |=> LOW_BYTE_FLAG_N_O && LOW_BYTE_FLAG_OE ##1 (r.state == SEQ_IDLE)
	) else $error("end of transfer not marked");

	a_demand_push: assert property (
		mode_s && !r.mode_d |=> r.push_pend
	) else $error("mode rise did not queue result");

	a_direct_all: assert property (
		!mode_s && (r.state == SEQ_IDLE) && !ce_n_s && !hb_n_s && !lb_n_s
		|=> DATA_OE == 14'h3FFF
	) else $error("direct enable did not drive all outputs");

	a_status_fall: assert property (
		CONV_DONE |=> !STATUS && (DATA_O == r.latest || r.state != SEQ_IDLE || mode_s)
	) else $error("status did not fall on new data");

	a_start_run: assert property (
		CONV_START |-> $past(run_s) && STATUS
	) else $error("conversion started without run");

	a_high_byte_map: assert property (
		$rose(r.state == SEQ_HI_STROBE) |-> DATA_O[`HI_BYTE_MSB:`HI_BYTE_LSB] ==
			{r.cur.polarity_bit, r.cur.overrange, r.cur.result_bits[11:8]}
	) else $error("high byte content wrong");

	sequence s_lo_presented;
		!LOW_BYTE_FLAG_N_O && LOW_BYTE_FLAG_OE && (DATA_OE == 14'h00FF);
	endsequence

	a_hold_low: assert property (
		(r.state == SEQ_LO_HOLD) && !send_s |=> (r.state == SEQ_LO_HOLD) ##0 s_lo_presented
	) else $error("low byte dropped while send low");

	a_low_byte_map: assert property (
		$rose(r.state == SEQ_LO_STROBE) |->
			DATA_O[`LO_BYTE_MSB:`LO_BYTE_LSB] == r.cur.result_bits[7:0]
	) else $error("low byte content wrong");

	a_no_early_advance: assert property (
		(r.state == SEQ_HI_HOLD) && !r.saw_low && send_s |=> (r.state == SEQ_HI_HOLD)
	) else $error("advanced without send going low");

	a_flags_driven: assert property (
		r.state != SEQ_IDLE |-> HIGH_BYTE_FLAG_OE && LOW_BYTE_FLAG_OE && CE_LOAD_OE
	) else $error("handshake pins released mid-sequence");

	a_every_result: assert property (
		CONV_DONE && mode_s |=> r.push_pend
	) else $error("completed result not queued");
endmodule // adc_handshake_byte_output

// ### rtl/pin_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1,
	// Level both stages take in reset; should match the pins' idle levels
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock, reset and enable
	input logic clk,
	input logic rst_n,
	input logic ce,
	// Asynchronous in, synchronous out
	input logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} sync_s;

	sync_s r;
	sync_s n;

	assign q = r.second;

	always_comb begin
		n = r;
		n.first = d;
		n.second = r.first;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{first: RST_VAL, second: RST_VAL};
		end else if (ce) begin
			r <= n;
		end
	end
endmodule // pin_sync

// ### rtl/result_fifo.sv
// Small FIFO of conversion results waiting to be shipped
`timescale 1ns/10ps
module result_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 4
) (
	// Clock, reset and enable
	input logic clk,
	input logic rst_n,
	input logic ce,
	// Filling side
	input logic in_valid,
	output logic in_ready,
	input logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [CW-1:0] count;
	} fifo_s;

	fifo_s r;
	fifo_s n;
	logic push;
	logic pop;

	assign in_ready = r.count != CW'(DEPTH);
	assign out_valid = r.count != '0;
	assign out_data = r.mem[r.rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wptr] = in_data;
			n.wptr = (r.wptr == AW'(DEPTH - 1)) ? '0 : r.wptr + 1'b1;
		end
		if (pop) begin
			n.rptr = (r.rptr == AW'(DEPTH - 1)) ? '0 : r.rptr + 1'b1;
		end
		if (push && !pop) begin
			n.count = r.count + 1'b1;
		end else if (pop && !push) begin
			n.count = r.count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else if (ce) begin
			r <= n;
		end
	end
endmodule // result_fifo

// ### tb/byte_receiver.sv
// Receiver model that takes bytes off the handshake port and paces it with send
`timescale 1ns/10ps
module byte_receiver (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins from the converter
	input wire logic load_n,
	input wire logic hi_n,
	input wire logic [13:0] bus,
	// Pacing
	input wire logic [7:0] stall,
	output logic send,
	// Bytes taken
	output logic got,
	output logic got_hi,
	output logic [7:0] got_byte
);
	logic load_d = 1'b1;
	logic busy = 1'b0;
	logic [7:0] wait_cnt = 8'h00;
	initial send = 1'b1;
	initial got = 1'b0;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			send <= 1'b1;
			got <= 1'b0;
			load_d <= 1'b1;
			busy <= 1'b0;
		end else begin
			load_d <= load_n;
			got <= 1'b0;
			if (load_n && !load_d) begin
				// Byte latched on the rising edge of the load strobe
				got <= 1'b1;
				got_hi <= !hi_n;
				got_byte <= !hi_n ? {2'b00, bus[13:8]} : bus[7:0];
				send <= 1'b0;
				wait_cnt <= stall;
				busy <= 1'b1;
			end else if (busy && wait_cnt == 8'h00) begin
				send <= 1'b1;
				busy <= 1'b0;
			end else if (busy) begin
				wait_cnt <= wait_cnt - 8'h01;
			end
		end
	end
endmodule // byte_receiver

// ### tb/tb_top.sv
// Bench for the handshake byte output sequencer
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	import adc_hs_pkg::*;
	typedef struct packed {
		result_s res;
		logic [5:0] hi;
		logic [7:0] lo;
	} row_s;
	row_s rows[4] = '{
		'{result_s'(14'h3FFF), 6'h3F, 8'hFF},
		'{result_s'(14'h2001), 6'h20, 8'h01},
		'{result_s'(14'h1E80), 6'h1E, 8'h80},
		'{result_s'(14'h0C3C), 6'h0C, 8'h3C}
	};
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic MODE = 1'b0;
	logic RUN_HOLD = 1'b0;
	logic CONV_DONE = 1'b0;
	result_s CONV_RESULT = '0;
	logic ce_ext = 1'b1;
	logic hb_ext = 1'b1;
	logic lb_ext = 1'b1;
	logic [7:0] stall = 8'h00;
	logic SEND, STATUS, CONV_START, got, got_hi;
	logic [7:0] got_byte;
	logic CE_LOAD_N_I, CE_LOAD_N_O, CE_LOAD_OE;
	logic HIGH_BYTE_FLAG_N_I, HIGH_BYTE_FLAG_N_O, HIGH_BYTE_FLAG_OE;
	logic LOW_BYTE_FLAG_N_I, LOW_BYTE_FLAG_N_O, LOW_BYTE_FLAG_OE;
	logic [13:0] DATA_O, DATA_OE, bus;
	logic [8:0] rx_q[$];
	int err_count = 0;
	int cmp_count = 0;

	// Pin levels seen by every party; released data bits show the inverse
	assign CE_LOAD_N_I = CE_LOAD_OE ? CE_LOAD_N_O : ce_ext;
	assign HIGH_BYTE_FLAG_N_I = HIGH_BYTE_FLAG_OE ? HIGH_BYTE_FLAG_N_O : hb_ext;
	assign LOW_BYTE_FLAG_N_I = LOW_BYTE_FLAG_OE ? LOW_BYTE_FLAG_N_O : lb_ext;
	assign bus = DATA_O ~^ DATA_OE;

	adc_handshake_byte_output adc_handshake_byte_output_i (
		.SYS_CLK, .RST_N, .CLK_EN(1'b1), .MODE, .SEND, .RUN_HOLD, .STATUS,
		.CE_LOAD_N_I, .CE_LOAD_N_O, .CE_LOAD_OE,
		.HIGH_BYTE_FLAG_N_I, .HIGH_BYTE_FLAG_N_O, .HIGH_BYTE_FLAG_OE,
		.LOW_BYTE_FLAG_N_I, .LOW_BYTE_FLAG_N_O, .LOW_BYTE_FLAG_OE,
		.DATA_O, .DATA_OE, .CONV_DONE, .CONV_RESULT, .CONV_START
	);
	byte_receiver byte_receiver_i (
		.clk(SYS_CLK), .rst_n(RST_N), .load_n(CE_LOAD_N_I), .hi_n(HIGH_BYTE_FLAG_N_I),
		.bus(bus), .stall(stall), .send(SEND), .got(got), .got_hi(got_hi),
		.got_byte(got_byte)
	);

	always @(posedge SYS_CLK) if (got) rx_q.push_back({got_hi, got_byte});

	initial forever #5 SYS_CLK = ~SYS_CLK;

	task automatic end_of_test;
		if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge SYS_CLK);
	endtask
	task automatic wait_q(input int n);
		int k;
		for (k = 0; k < 400 && rx_q.size() < n; k++) @(negedge SYS_CLK);
		if (rx_q.size() < n) begin
			err_count++;
			$display("ERROR bytes exp %0d got %0d", n, rx_q.size());
			end_of_test();
		end
	endtask
	task automatic conv(input result_s r);
		@(posedge SYS_CLK);
		CONV_DONE <= 1'b1;
		CONV_RESULT <= r;
		@(posedge SYS_CLK);
		CONV_DONE <= 1'b0;
		@(posedge SYS_CLK);
	endtask

	initial begin
		int i;
		int k;
		repeat (20) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		cycles(1);
		`CHK("data_oe", 14'h0000, DATA_OE)
		`CHK("load_oe", 1'b0, CE_LOAD_OE)
		// Conversion on command, status falls on new data
		@(posedge SYS_CLK) RUN_HOLD <= 1'b1;
		for (k = 0; k < 20 && CONV_START !== 1'b1; k++) @(negedge SYS_CLK);
		`CHK("start", 1'b1, CONV_START)
		`CHK("status", 1'b1, STATUS)
		if (k >= 20) begin
			err_count++;
			end_of_test();
		end
		@(posedge SYS_CLK) RUN_HOLD <= 1'b0;
		conv(result_s'(14'h35A5));
		cycles(2);
		`CHK("status", 1'b0, STATUS)
		// Direct mode enables
		@(posedge SYS_CLK);
		ce_ext <= 1'b0;
		hb_ext <= 1'b0;
		lb_ext <= 1'b0;
		cycles(5);
		`CHK("data_oe", 14'h3FFF, DATA_OE)
		`CHK("data", 14'h35A5, DATA_O)
		@(posedge SYS_CLK) hb_ext <= 1'b1;
		cycles(5);
		`CHK("data_oe", 14'h00FF, DATA_OE)
		@(posedge SYS_CLK);
		ce_ext <= 1'b1;
		lb_ext <= 1'b1;
		// Deselecting looks like a load edge to the receiver; drop that byte
		cycles(4);
		rx_q.delete();
		// On-demand ship with a receiver that keeps send low a long time
		@(posedge SYS_CLK);
		stall <= 8'h28;
		MODE <= 1'b1;
		wait_q(1);
		cycles(20);
		`CHK("hi_flag", 1'b0, HIGH_BYTE_FLAG_N_O)
		`CHK("data_oe", 14'h3F00, DATA_OE)
		`CHK("bytes", 1, rx_q.size())
		`CHK("pin_oe", 3'b111, {CE_LOAD_OE, HIGH_BYTE_FLAG_OE, LOW_BYTE_FLAG_OE})
		wait_q(2);
		`CHK("hi", 9'h135, rx_q[0])
		`CHK("lo", 9'h0A5, rx_q[1])
		for (k = 0; k < 100 && DATA_OE !== 14'h0000; k++) @(negedge SYS_CLK);
		`CHK("lo_flag", 1'b1, LOW_BYTE_FLAG_N_O)
		if (k >= 100) begin
			err_count++;
			end_of_test();
		end
		rx_q.delete();
		// Results queue up while the receiver is slow
		@(posedge SYS_CLK) stall <= 8'h0C;
		for (i = 0; i < 4; i++) conv(rows[i].res);
		wait_q(8);
		for (i = 0; i < 4; i++) begin
			`CHK("hi", {3'b100, rows[i].hi}, rx_q[2 * i])
			`CHK("lo", {1'b0, rows[i].lo}, rx_q[2 * i + 1])
		end
		// Reset in the middle of a handshake drops every pin driver at once
		@(posedge SYS_CLK) RST_N <= 1'b0;
		cycles(2);
		`CHK("rst_oe", 17'h00000, {DATA_OE, CE_LOAD_OE, HIGH_BYTE_FLAG_OE, LOW_BYTE_FLAG_OE})
		`CHK("rst_status", 1'b0, STATUS)
		@(posedge SYS_CLK) RST_N <= 1'b1;
		cycles(2);
		`CHK("rst_data_oe", 14'h0000, DATA_OE)
		end_of_test();
	end
endmodule // tb_top
